// ### shared/sctm_cfg.svh
`ifndef SCTM_CFG_SVH
`define SCTM_CFG_SVH

`define SCTM_WORD_W        24
`define SCTM_ADDR_W        4
// Word address codes in the low nibble; word zero only needs bit 0 low
`define SCTM_ADDR_W1       4'h3
`define SCTM_ADDR_W2       4'h5
`define SCTM_ADDR_W3       4'h7
`define SCTM_ADDR_W4       4'h9
`define SCTM_ADDR_W5       4'hb
`define SCTM_ADDR_W6       4'hd
`define SCTM_ADDR_W7       4'hf
// Power-down bit inside words one and two
`define SCTM_PD_BIT        23
// Access bits inside word three
`define SCTM_ACC_LSB       20
// Main configuration word fields
`define SCTM_AUTO_POWER_UP_BIT      23
`define SCTM_DITHER_SELECT_LSB      16
`define SCTM_ORDER_LSB     14
`define SCTM_DBL_BIT       12
`define SCTM_OBUF_BIT      11
`define SCTM_AUXPOL_BIT    10
`define SCTM_MAINPOL_BIT   9
`define SCTM_PRESC_BIT     8
`define SCTM_SEL_LSB       4
// Optional word fields
`define SCTM_FDEN_LSB      14
`define SCTM_FNUM_LSB      4
`define SCTM_CSR_LSB       22
`define SCTM_CPF_LSB       18
`define SCTM_TOC_LSB       4
`define SCTM_LDADJ_BIT     13
`define SCTM_AUXRST_BIT    7
`define SCTM_MAINRST_BIT   6
`define SCTM_AUXTRI_BIT    5
`define SCTM_MAINTRI_BIT   4
// Reset and default word contents
`define SCTM_W3_RESET      24'h100007
`define SCTM_W4_RESET      24'h22c709
`define SCTM_W5_DEFAULT    24'h00000b
`define SCTM_W6_DEFAULT    24'h00000d
`define SCTM_W7_DEFAULT    24'h00090f

`endif

// ### shared/sctm_pkg.sv
package sctm_pkg;

  typedef struct packed {
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        clk_prev;
    logic        le_prev;
    logic [23:0] shift;
    logic [23:0] word;
    logic        valid;
  } sctm_rx_state_t;

  typedef struct packed {
    logic        main_pd;
    logic        aux_pd;
    logic [23:0] w3;
    logic [23:0] w4;
    logic [23:0] w5;
    logic [23:0] w6;
    logic [23:0] w7;
    logic [3:0]  div_tgl;
    logic        pin_out;
    logic        pin_oe;
  } sctm_bank_state_t;

  typedef struct packed {
    logic [1:0] digital;  // {aux, main}
    logic [1:0] analog;   // {aux, main}
  } sctm_lock_t;

  typedef struct packed {
    logic        auto_power_up;
    logic [1:0]  dither_select;
    logic [1:0]  modulator_order;
    logic        ref_doubler_enable;
    logic        ref_buffer_out_enable;
    logic        aux_pump_polarity;
    logic        main_pump_polarity;
    logic        aux_prescaler_16;
    logic [3:0]  test_pin_select;
    logic        extended_fraction;
    logic [9:0]  fraction_denominator_high;
    logic [9:0]  fraction_numerator_high;
    logic [1:0]  slip_reduction;
    logic [3:0]  fastlock_pump_current;
    logic [13:0] fastlock_timeout;
    logic        lock_detect_adjust;
    logic        aux_counter_reset;
    logic        main_counter_reset;
    logic        aux_pump_tristate;
    logic        main_pump_tristate;
    logic        main_power_down;
    logic        aux_power_down;
  } sctm_config_t;

endpackage

// ### rtl/sctm_serial_rx.sv
`timescale 1ns/10ps
`include "sctm_cfg.svh"

module sctm_serial_rx (
  input  wire logic                       sys_clk,     // System clock
  input  wire logic                       rst_b,       // Async reset
  input  wire logic                       clk_en,      // Freeze when low
  input  wire logic                       ser_clk,     // Serial clock pin
  input  wire logic                       ser_data,    // Serial data pin
  input  wire logic                       ser_latch,   // Latch enable pin
  input  wire logic                       chip_enable, // Chip enable pin
  output logic [`SCTM_WORD_W-1:0]         word,        // Last latched word
  output logic                            word_valid,  // One-cycle strobe
  output logic                            ce_level     // Synced enable
);

  sctm_pkg::sctm_rx_state_t st;
  sctm_pkg::sctm_rx_state_t next_st;
  logic                     clk_rise;
  logic                     le_rise;

  // sync2 bit order: {chip_enable, latch, data, clock}
  assign clk_rise = st.sync2[0] && !st.clk_prev;
  assign le_rise  = st.sync2[2] && !st.le_prev;

  always_comb begin
    next_st          = st;
    next_st.sync1    = {chip_enable, ser_latch, ser_data, ser_clk};
    next_st.sync2    = st.sync1;
    next_st.clk_prev = st.sync2[0];
    next_st.le_prev  = st.sync2[2];
    next_st.valid    = 1'b0;
    // Data arrives most significant bit first
    if (clk_rise) begin
      next_st.shift = {st.shift[22:0], st.sync2[1]};
    end
    if (le_rise) begin
      next_st.word  = st.shift;
      next_st.valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign word       = st.word;
  assign word_valid = st.valid;
  assign ce_level   = st.sync2[3];

  a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    word_valid && clk_en |=> !word_valid)
    else $error("word strobe longer than one cycle");

endmodule

// ### rtl/sctm_config_mux.sv
`timescale 1ns/10ps
`include "sctm_cfg.svh"

module sctm_config_mux #(
  parameter int WORD_W = `SCTM_WORD_W
) (
  input  wire logic                 sys_clk,       // 20 MHz clock
  input  wire logic                 rst_b,         // Async reset
  input  wire logic                 clk_en,        // Freeze when low
  input  wire logic                 ser_clk,       // Serial clock pin
  input  wire logic                 ser_data,      // Serial data pin
  input  wire logic                 ser_latch,     // Latch enable pin
  input  wire logic                 chip_enable,   // Chip enable pin
  input  wire sctm_pkg::sctm_lock_t lock_ind,      // Lock indications
  input  wire logic [3:0]           div_pulse,     // Divider pulses
  output sctm_pkg::sctm_config_t    cfg,           // Decoded settings
  output logic                      test_lock_pin, // Test pin level
  output logic                      test_lock_oe,  // Test pin drive
  output logic                      access_fault   // Access bit 0 low
);

  sctm_pkg::sctm_bank_state_t st;
  sctm_pkg::sctm_bank_state_t next_st;
  logic [WORD_W-1:0]          word;
  logic                       word_valid;
  logic                       ce_level;
  logic [3:0]                 addr;
  logic [3:0]                 acc;
  logic [WORD_W-1:0]          eff5;
  logic [WORD_W-1:0]          eff6;
  logic [WORD_W-1:0]          eff7;
  logic [3:0]                 sel;
  logic [3:0]                 tgl_next;
  logic                       ana;

  sctm_serial_rx u_rx (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .clk_en      (clk_en),
    .ser_clk     (ser_clk),
    .ser_data    (ser_data),
    .ser_latch   (ser_latch),
    .chip_enable (chip_enable),
    .word        (word),
    .word_valid  (word_valid),
    .ce_level    (ce_level)
  );

  assign addr = word[3:0];
  assign acc  = st.w3[`SCTM_ACC_LSB+3:`SCTM_ACC_LSB];
  assign sel  = st.w4[`SCTM_SEL_LSB+3:`SCTM_SEL_LSB];

  // Optional words read as defaults while their access bit is clear
  assign eff5 = acc[1] ? st.w5 : `SCTM_W5_DEFAULT;
  assign eff6 = acc[2] ? st.w6 : `SCTM_W6_DEFAULT;
  assign eff7 = acc[3] ? st.w7 : `SCTM_W7_DEFAULT;

  // Divider outputs halved by one toggle flop each
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      assign tgl_next[gi] = st.div_tgl[gi] ^ div_pulse[gi];
    end
  endgenerate

  always_comb begin
    next_st         = st;
    next_st.div_tgl = tgl_next;
    ana             = 1'b0;
    if (word_valid) begin
      if (!addr[0]) begin
        // Hardware power-down via chip enable blocks the automatic clear
        if (st.w4[`SCTM_AUTO_POWER_UP_BIT] && ce_level) begin
          next_st.main_pd = 1'b0;
          next_st.aux_pd  = 1'b0;
        end
      end else begin
        unique case (addr)
          `SCTM_ADDR_W1: next_st.main_pd = word[`SCTM_PD_BIT];
          `SCTM_ADDR_W2: next_st.aux_pd  = word[`SCTM_PD_BIT];
          `SCTM_ADDR_W3: next_st.w3      = word;
          `SCTM_ADDR_W4: next_st.w4      = word;
          `SCTM_ADDR_W5: if (acc[1]) next_st.w5 = word;
          `SCTM_ADDR_W6: if (acc[2]) next_st.w6 = word;
          `SCTM_ADDR_W7: if (acc[3]) next_st.w7 = word;
          default: ;
        endcase
      end
    end
    // Pin is registered so the driver never glitches between codes
    case (sel)
      4'h0: begin
        next_st.pin_oe  = 1'b0;
        next_st.pin_out = 1'b0;
      end
      4'h1: begin
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = 1'b1;
      end
      4'h2: begin
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = 1'b0;
      end
      4'h3, 4'h4, 4'h5: begin
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = (sel == 4'h3) ? &lock_ind.digital
                        : lock_ind.digital[sel == 4'h5];
      end
      4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb: begin
        if (sel == 4'h6 || sel == 4'h9) begin
          ana = &lock_ind.analog;
        end else begin
          ana = lock_ind.analog[sel == 4'h8 || sel == 4'hb];
        end
        // Open-drain pulls low when unlocked and releases when locked
        if (sel <= 4'h8) begin
          next_st.pin_oe  = !ana;
          next_st.pin_out = 1'b0;
        end else begin
          next_st.pin_oe  = 1'b1;
          next_st.pin_out = ana;
        end
      end
      default: begin
        // Order: aux ref, aux feedback, main ref, main feedback
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = st.div_tgl[sel[1:0]];
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st         <= '0;
      st.w3      <= `SCTM_W3_RESET;
      st.w4      <= `SCTM_W4_RESET;
      st.w5      <= `SCTM_W5_DEFAULT;
      st.w6      <= `SCTM_W6_DEFAULT;
      st.w7      <= `SCTM_W7_DEFAULT;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign test_lock_pin = st.pin_out;
  assign test_lock_oe  = st.pin_oe;
  assign access_fault  = !acc[0];

  always_comb begin
    cfg                        = '0;
    cfg.auto_power_up          = st.w4[`SCTM_AUTO_POWER_UP_BIT];
    cfg.dither_select          = st.w4[`SCTM_DITHER_SELECT_LSB+1:`SCTM_DITHER_SELECT_LSB];
    cfg.modulator_order        = st.w4[`SCTM_ORDER_LSB+1:`SCTM_ORDER_LSB];
    cfg.ref_doubler_enable     = st.w4[`SCTM_DBL_BIT];
    cfg.ref_buffer_out_enable  = st.w4[`SCTM_OBUF_BIT];
    cfg.aux_pump_polarity      = st.w4[`SCTM_AUXPOL_BIT];
    cfg.main_pump_polarity     = st.w4[`SCTM_MAINPOL_BIT];
    cfg.aux_prescaler_16       = st.w4[`SCTM_PRESC_BIT];
    cfg.test_pin_select        = sel;
    cfg.extended_fraction      = acc[1];
    cfg.fraction_denominator_high = eff5[`SCTM_FDEN_LSB+9:`SCTM_FDEN_LSB];
    cfg.fraction_numerator_high   = eff5[`SCTM_FNUM_LSB+9:`SCTM_FNUM_LSB];
    cfg.slip_reduction         = eff6[`SCTM_CSR_LSB+1:`SCTM_CSR_LSB];
    cfg.fastlock_pump_current  = eff6[`SCTM_CPF_LSB+3:`SCTM_CPF_LSB];
    cfg.fastlock_timeout       = eff6[`SCTM_TOC_LSB+13:`SCTM_TOC_LSB];
    cfg.lock_detect_adjust     = eff7[`SCTM_LDADJ_BIT];
    cfg.aux_counter_reset      = eff7[`SCTM_AUXRST_BIT];
    cfg.main_counter_reset     = eff7[`SCTM_MAINRST_BIT];
    cfg.aux_pump_tristate      = eff7[`SCTM_AUXTRI_BIT];
    cfg.main_pump_tristate     = eff7[`SCTM_MAINTRI_BIT];
    // Chip enable low overrides the software power-down bits
    cfg.main_power_down        = st.main_pd || !ce_level;
    cfg.aux_power_down         = st.aux_pd || !ce_level;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_w4_fields: assert property (word_valid && addr == `SCTM_ADDR_W4 && clk_en
    |=> cfg.test_pin_select == $past(word[7:4])
        && cfg.auto_power_up == $past(word[23]))
    else $error("main word fields not captured");
  a_pin_float: assert property (clk_en && sel == 4'h0
    |=> !test_lock_oe)
    else $error("pin driven while select is zero");
  a_pin_high: assert property (clk_en && sel == 4'h1
    |=> test_lock_oe && test_lock_pin)
    else $error("pin not high for select one");
  a_dig_lock: assert property (clk_en && sel == 4'h3
    |=> test_lock_oe && test_lock_pin == $past(&lock_ind.digital))
    else $error("combined digital lock wrong");
  a_open_drain: assert property (clk_en && sel >= 4'h6 && sel <= 4'h8
    |=> !test_lock_pin)
    else $error("open-drain pin driven high");
  a_div_half: assert property (clk_en && div_pulse[0]
    |=> st.div_tgl[0] != $past(st.div_tgl[0]))
    else $error("divider toggle missed");
  a_prescaler: assert property (word_valid && addr == `SCTM_ADDR_W4 && clk_en
    |=> cfg.aux_prescaler_16 == $past(word[8])
        && cfg.main_pump_polarity == $past(word[9]))
    else $error("prescaler or polarity bit wrong");
  a_r7_default: assert property (!acc[3]
    |-> !cfg.lock_detect_adjust && !cfg.main_counter_reset
        && !cfg.aux_counter_reset && !cfg.main_pump_tristate
        && !cfg.aux_pump_tristate)
    else $error("default word shows active control");
  a_auto_pwr_up: assert property (word_valid && !addr[0] && clk_en
    && st.w4[23] && ce_level |=> !st.main_pd && !st.aux_pd)
    else $error("auto power-up did not clear");
  a_access_gate: assert property (word_valid && addr == `SCTM_ADDR_W5
    && !acc[1] && clk_en |=> $stable(st.w5))
    else $error("non-accessed word was written");
  // Checks the capture path, not just the output inverter
  a_access_one: assert property (word_valid && addr == `SCTM_ADDR_W3
    && clk_en |=> access_fault == !$past(word[`SCTM_ACC_LSB]))
    else $error("access fault flag wrong");

  c_word0: cover property (word_valid && !addr[0] && st.w4[23]);
  c_open_drain: cover property (sel == 4'h7 && !test_lock_oe);
  c_div_out: cover property (sel == 4'hf && test_lock_pin);
  c_ext_frac: cover property (acc[1] && word_valid && addr == `SCTM_ADDR_W5);

endmodule

// ### verification/sctm_host.sv
`timescale 1ns/10ps

module sctm_host (
  input  wire logic sys_clk,   // System clock
  output logic      ser_clk,   // Serial clock to device
  output logic      ser_data,  // Serial data to device
  output logic      ser_latch  // Latch enable to device
);
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end

  // Four cycles per phase leaves margin over the two the synchroniser needs
  task automatic step();
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic write_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      step();
      ser_clk <= 1'b1;
      step();
      ser_clk <= 1'b0;
    end
    // Released data line must not keep looking like valid data
    ser_data <= ~w[0];
    step();
    ser_latch <= 1'b1;
    step();
    ser_latch <= 1'b0;
    step();
    step();
  endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/10ps

module tb;
  logic                   sys_clk;
  logic                   rst_b;
  logic                   clk_en;
  logic                   chip_enable;
  sctm_pkg::sctm_lock_t   lock_ind;
  logic [3:0]             div_pulse;
  sctm_pkg::sctm_config_t cfg;
  logic                   ser_clk;
  logic                   ser_data;
  logic                   ser_latch;
  logic                   pin;
  logic                   oe;
  logic                   fault;
  logic                   p0;
  logic [19:0]            f5;
  logic [19:0]            f6;
  logic [4:0]             f7;
  int                     err_count;
  int                     tests_run;
  // Select code, lock inputs {digital, analog}, expected {pin, oe}
  logic [11:0] rows [21] = '{12'h0f0, 12'h103, 12'h2f1, 12'h3c3, 12'h341,
    12'h443, 12'h481, 12'h583, 12'h541, 12'h630, 12'h611, 12'h710, 12'h721,
    12'h820, 12'h811, 12'h933, 12'h921, 12'ha13, 12'hac1, 12'hb23, 12'hb11};

  assign f5 = {cfg.fraction_denominator_high, cfg.fraction_numerator_high};
  assign f6 = {cfg.slip_reduction, cfg.fastlock_pump_current,
               cfg.fastlock_timeout};
  assign f7 = {cfg.lock_detect_adjust, cfg.aux_counter_reset,
               cfg.main_counter_reset, cfg.aux_pump_tristate,
               cfg.main_pump_tristate};

  sctm_config_mux sctm_config_mux_i (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .clk_en        (clk_en),
    .ser_clk       (ser_clk),
    .ser_data      (ser_data),
    .ser_latch     (ser_latch),
    .chip_enable   (chip_enable),
    .lock_ind      (lock_ind),
    .div_pulse     (div_pulse),
    .cfg           (cfg),
    .test_lock_pin (pin),
    .test_lock_oe  (oe),
    .access_fault  (fault)
  );

  sctm_host sctm_host_i (
    .sys_clk   (sys_clk),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_latch (ser_latch)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("checks=%0d errors=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [23:0] w);
    sctm_host_i.write_word(w);
  endtask

  task automatic pulse(input logic [3:0] m);
    div_pulse <= m;
    @(posedge sys_clk);
    div_pulse <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic fields(input logic [23:0] w);
    wr(w);
    chk({cfg.auto_power_up, cfg.dither_select, cfg.modulator_order,
         cfg.ref_doubler_enable, cfg.ref_buffer_out_enable,
         cfg.aux_pump_polarity, cfg.main_pump_polarity,
         cfg.aux_prescaler_16, cfg.test_pin_select},
        {w[23], w[17:14], w[12:4]});
  endtask

  // Chip enable is dropped only around the word zero write
  task automatic pd_chk(input logic [23:0] w4, input logic ce,
                        input logic exp);
    wr(w4);
    wr(24'h800003);
    wr(24'h800005);
    chip_enable <= ce;
    wr(24'h000000);
    chip_enable <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({cfg.main_power_down, cfg.aux_power_down}, {exp, exp});
  endtask

  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end

  initial begin
    sys_clk     = 1'b0;
    rst_b       = 1'b0;
    chip_enable = 1'b1;
    clk_en      = 1'b1;
    lock_ind    = '0;
    div_pulse   = 4'h0;
    err_count   = 0;
    tests_run   = 0;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(f7, 24'h0);
    chk(f5, 24'h0);
    chk(f6, 24'h0);
    chk(cfg.main_pump_polarity, 24'h1);
    chk(fault, 24'h0);
    chk(cfg.extended_fraction, 24'h0);
    for (int i = 0; i < 21; i++) begin
      lock_ind <= rows[i][7:4];
      wr({16'h224a, rows[i][11:8], 4'h9});
      chk(oe, rows[i][0]);
      if (rows[i][11:8] != 4'h0) begin
        chk(pin, rows[i][1]);
      end
    end
    fields(24'ha19539);
    fields(24'h224a09);
    for (int k = 0; k < 4; k++) begin
      wr({16'h224a, 4'hc + 4'(k), 4'h9});
      p0 = pin;
      pulse(~(4'h1 << k));
      chk(pin, p0);
      pulse(4'h1 << k);
      chk(pin, !p0);
      pulse(4'h1 << k);
      chk({oe, pin}, {1'b1, p0});
    end
    // Optional words addressed while their access bits are clear
    wr(24'hfffffb);
    wr(24'hfffffd);
    wr(24'hffffff);
    chk(f5, 24'h0);
    chk(f6, 24'h0);
    chk(f7, 24'h0);
    wr(24'hf00007);
    wr(24'h80001b);
    wr(24'h9abcdd);
    wr(24'h0020ff);
    chk(f5, 20'h80001);
    chk(f6, 20'h9abcd);
    chk(f7, 5'h1f);
    chk(cfg.extended_fraction, 24'h1);
    wr(24'he00007);
    chk(fault, 24'h1);
    wr(24'h100007);
    chk({fault, f7}, 24'h0);
    pd_chk(24'ha19539, 1'b1, 1'b0);
    pd_chk(24'h224a09, 1'b1, 1'b1);
    pd_chk(24'ha19539, 1'b0, 1'b1);
    // A frozen clock enable must hold the pin through a lock change
    clk_en   <= 1'b0;
    lock_ind <= 4'hc;
    repeat (4) @(posedge sys_clk);
    chk(pin, 24'h0);
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(pin, 24'h1);
    // Mid-run reset returns select to zero and clears power-downs
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({oe, cfg.test_pin_select, cfg.main_power_down,
         cfg.aux_power_down}, 24'h0);
    end_sim();
  end
endmodule
